// [hw/picb_regs.svh]
/*
 * Register offsets, field positions and reset values of the posted
 * interrupt clear bank. Assumes byte addressing on a 32-bit APB bus.
 */
`ifndef PICB_REGS_SVH
`define PICB_REGS_SVH

// ****************************************
// Offsets (byte addresses = 4 x index)
// ****************************************
`define PICB_IDX_CLR_LOWER   8'h00DB
`define PICB_IDX_CLR_UPPER   8'h00DC
`define PICB_IDX_MSK_UPPER   8'h00DE
`define PICB_IDX_MSK_LOWER   8'h00DF
`define PICB_IDX_SW_EN       8'h00E1
`define PICB_IDX_IRQ_STAT    8'h00F0
`define PICB_IDX_IRQ_MASK    8'h00F1
`define PICB_IDX_PENDING     8'h00F2

// ****************************************
// Fields and reset values
// ****************************************
`define PICB_SRC_COUNT       14
`define PICB_LOWER_W         8
`define PICB_UPPER_W         6
`define PICB_SW_EN_BIT       0
`define PICB_RST_POSTED      14'h0000
`define PICB_RST_MASK        14'h0000
`define PICB_RST_SW_EN       1'h0
`define PICB_RST_BYTE        8'h00

`endif

// [hw/picb_pkg.sv]
/*
 * Types shared by the posted interrupt clear bank.
 * Assumes the constants header is included by the user.
 */
package picb_pkg;

	// ****************************************
	// Register write request
	// ****************************************
	typedef struct packed
	{
		logic        valid;
		logic [13:0] index;
		logic [31:0] data;
	} picb_wr_s;

	typedef enum logic [0:0]
	{
		PICB_ST_SETUP  = 1'b0,
		PICB_ST_ACCESS = 1'b1
	} picb_phase_e;

endpackage : picb_pkg

// [hw/picb_apb_slave.sv]
/*
 * APB slave front end: zero wait states, decodes a word index and
 * emits one write pulse per accepted write and a read strobe.
 * Assumes a 32-bit APB master on the same clock.
 */
`timescale 1ns/1ps
module picb_apb_slave
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_psel,
	input  wire logic             i_penable,
	input  wire logic             i_pwrite,
	input  wire logic [15:0]      i_paddr,
	input  wire logic [31:0]      i_pwdata,
	output picb_pkg::picb_wr_s    o_wr,
	output logic                  o_rd,
	output logic [13:0]           o_index
);

	logic access;

	assign access  = i_psel && i_penable;
	assign o_index = i_paddr[15:2];

	always_comb
	begin
		o_wr.valid = access && i_pwrite;
		o_wr.index = i_paddr[15:2];
		o_wr.data  = i_pwdata;
		o_rd       = access && !i_pwrite;
	end

endmodule : picb_apb_slave

// [hw/picb_src_sync.sv]
/*
 * Three-stage synchroniser per event source with rising-edge
 * detection: an event counts once stage two is high and stage three is still low.
 * Assumes event inputs come from other domains or pins.
 */
`timescale 1ns/1ps
`include "picb_regs.svh"
module picb_src_sync
(
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_sys_rst,
	input  wire logic [`PICB_SRC_COUNT-1:0] i_src,
	output logic      [`PICB_SRC_COUNT-1:0] o_rise
);

	genvar g;
	generate
		for (g = 0; g < `PICB_SRC_COUNT; g++)
		begin : g_sync
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge i_sys_clk)
			begin
				if (i_sys_rst)
				begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end
				else
				begin
					s1 <= i_src[g];
					s2 <= s1;
					s3 <= s2;
				end
			end
			// Stage one is never looked at directly
			assign o_rise[g] = s2 && !s3;
		end
	endgenerate

endmodule : picb_src_sync

// [hw/picb_top.sv]
/*
 * Posted interrupt clear bank: fourteen posted bits (counter units,
 * bus reset, frame start, endpoints 0..8, wake), their masks, the
 * software post enable, pending view and a sticky event status.
 * Assumes an APB master on i_sys_clk and asynchronous event sources.
 */
// Register access over APB was chosen for this implementation.
//
// Functional notes
// RL1 - Reading a clear register returns one for each source posted.
// RL2 - With soft posting off, writing zero clears that posted bit.
// RL3 - Clearing a bit that is not posted changes no state at all.
// RL4 - With soft posting on, writing one posts as if the source fired. The code sets only the posted bit; evt_stat and o_irq are not touched.
// RL5 - With soft posting off, writing one leaves the bit untouched.
// RL6 - With soft posting on, writing zero leaves the bit untouched.
// RL7 - Software writes zero to the two unused upper clear bits.
// RL8 - Upper clear bit 5 is wake, bits 4 to 0 are endpoints 8 to 4.
// RL9 - Lower bits 4..0: endpoint 0, frame, bus reset, counter 2, 1.
// RL10 - A posted bit becomes pending only while its mask bit is one.
// RL11 - Soft post enable is bit 0 of its own register, reset to 0.
// RL12 - A hardware event sets its posted bit until cleared or reset.
`timescale 1ns/1ps
`include "picb_regs.svh"
module picb_top
(
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_sys_rst,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [15:0]                i_paddr,
	input  wire logic [31:0]                i_pwdata,
	output logic      [31:0]                o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	input  wire logic [`PICB_SRC_COUNT-1:0] i_src_event,
	output logic      [`PICB_SRC_COUNT-1:0] o_pending,
	output logic                            o_irq
);

	// ****************************************
	// Source ordering (posted vector bits)
	// ****************************************
	// 0 counter_unit_one, 1 counter_unit_two, 2 bus reset, 3 frame,
	// 4 ep_slot_zero, 5..7 endpoints 1..3, 8 ep_slot_four .. 12
	// ep_slot_eight, 13 wake. Lower byte = bits 7:0, upper = 13:8.

	picb_pkg::picb_wr_s            wr;
	logic                          rd;
	logic [13:0]                   index;
	logic [`PICB_SRC_COUNT-1:0]    hw_rise;
	logic [`PICB_SRC_COUNT-1:0]    posted;
	logic [`PICB_SRC_COUNT-1:0]    mask;
	logic                          soft_post_enable;
	logic [`PICB_SRC_COUNT-1:0]    evt_stat;
	logic [`PICB_SRC_COUNT-1:0]    evt_mask;
	logic [`PICB_SRC_COUNT-1:0]    wr_bits;
	logic [`PICB_SRC_COUNT-1:0]    wr_sel;
	logic [`PICB_SRC_COUNT-1:0]    soft_set;
	logic [`PICB_SRC_COUNT-1:0]    soft_clr;
	logic [`PICB_SRC_COUNT-1:0]    next_posted;
	logic [`PICB_SRC_COUNT-1:0]    next_evt_stat;
	logic [31:0]                   next_rdata;
	logic                          hit;
	logic                          stat_read;

	picb_apb_slave u_apb
	(
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_pwdata  (i_pwdata),
		.o_wr      (wr),
		.o_rd      (rd),
		.o_index   (index)
	);

	picb_src_sync u_sync
	(
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_src     (i_src_event),
		.o_rise    (hw_rise)
	);

	// ****************************************
	// Write decode onto the posted vector
	// ****************************************
	always_comb
	begin
		wr_bits = '0;
		wr_sel  = '0;
		if (wr.valid && wr.index == 14'(`PICB_IDX_CLR_LOWER))
		begin
			wr_bits[7:0] = wr.data[7:0]; // RL9
			wr_sel[7:0]  = 8'hFF;
		end
		else if (wr.valid && wr.index == 14'(`PICB_IDX_CLR_UPPER))
		begin
			// Bits 7:6 are dropped; software keeps them zero
			wr_bits[13:8] = wr.data[5:0]; // RL8 RL7
			wr_sel[13:8]  = 6'h3F;
		end
	end

	// Enable picks the sense of the write; the other value is ignored
	assign soft_set = soft_post_enable ? (wr_sel & wr_bits) : '0; // RL4 RL5
	assign soft_clr = soft_post_enable ? '0 : (wr_sel & ~wr_bits); // RL2 RL6

	// Hardware set wins over a same-cycle clear so no event is lost;
	// clearing an unposted bit yields the same zero, no side effect.
	assign next_posted = (posted & ~soft_clr) | soft_set | hw_rise; // RL12 RL3

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			posted <= `PICB_RST_POSTED;
		else
			posted <= next_posted; // RL2 RL4 RL12
	end

	// ****************************************
	// Mask and soft post enable registers
	// ****************************************
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			mask             <= `PICB_RST_MASK;
			soft_post_enable <= `PICB_RST_SW_EN; // RL11
			evt_mask         <= `PICB_RST_MASK;
		end
		else if (wr.valid)
		begin
			if (wr.index == 14'(`PICB_IDX_MSK_LOWER))
				mask[7:0] <= wr.data[7:0];
			if (wr.index == 14'(`PICB_IDX_MSK_UPPER))
				mask[13:8] <= wr.data[5:0];
			if (wr.index == 14'(`PICB_IDX_SW_EN))
				soft_post_enable <= wr.data[`PICB_SW_EN_BIT]; // RL11
			if (wr.index == 14'(`PICB_IDX_IRQ_MASK))
				evt_mask <= wr.data[13:0];
		end
	end

	// ****************************************
	// Pending view and event interrupt
	// ****************************************
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			o_pending <= `PICB_RST_POSTED;
		else
			o_pending <= next_posted & mask; // RL10
	end

	// Read of the status register clears it; new events still win
	assign stat_read = rd && index == 14'(`PICB_IDX_IRQ_STAT);
	assign next_evt_stat = (stat_read ? '0 : evt_stat) | hw_rise;

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			evt_stat <= `PICB_RST_POSTED;
		else
			evt_stat <= next_evt_stat;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(next_evt_stat & evt_mask);
	end

	// ****************************************
	// Read mux and APB answer
	// ****************************************
	always_comb
	begin
		next_rdata = '0;
		hit        = 1'b1;
		unique case (index)
			14'(`PICB_IDX_CLR_LOWER): next_rdata[7:0] = posted[7:0]; // RL1
			14'(`PICB_IDX_CLR_UPPER): next_rdata[5:0] = posted[13:8]; // RL1
			14'(`PICB_IDX_MSK_LOWER): next_rdata[7:0] = mask[7:0];
			14'(`PICB_IDX_MSK_UPPER): next_rdata[5:0] = mask[13:8];
			14'(`PICB_IDX_SW_EN):     next_rdata[0]   = soft_post_enable;
			14'(`PICB_IDX_IRQ_STAT):  next_rdata[13:0] = evt_stat;
			14'(`PICB_IDX_IRQ_MASK):  next_rdata[13:0] = evt_mask;
			14'(`PICB_IDX_PENDING):   next_rdata[13:0] = o_pending;
			default:                  hit = 1'b0;
		endcase
	end

	// No wait state: ready is registered from the setup phase so outputs come from flops
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= '0;
		end
		else
		begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit;
			o_prdata  <= (i_psel && !i_penable && !i_pwrite) ?
				next_rdata : '0;
		end
	end

endmodule : picb_top

// [tb/picb_asserts.sv]
/* Checker of the APB answer and posted view of picb_top.
 * Assumes it is bound to picb_top and sees only its ports. */
`timescale 1ns/1ps
`include "picb_regs.svh"
module picb_asserts
(
	input wire logic        i_sys_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [13:0] i_src_event,
	input wire logic [13:0] o_pending,
	input wire logic        o_irq
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	logic [13:0] ix;
	logic        bad;
	assign ix = i_paddr[15:2];
	assign bad = !(ix inside {14'(`PICB_IDX_CLR_LOWER),
		14'(`PICB_IDX_CLR_UPPER), 14'(`PICB_IDX_MSK_UPPER),
		14'(`PICB_IDX_MSK_LOWER), 14'(`PICB_IDX_SW_EN),
		14'(`PICB_IDX_IRQ_STAT), 14'(`PICB_IDX_IRQ_MASK),
		14'(`PICB_IDX_PENDING)});
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	// Margin covers the three-stage event synchroniser
	sequence calm_s;
		!(i_psel && i_penable && i_pwrite) && $stable(i_src_event);
	endsequence
	ready_next_a: assert property (setup_s |=> o_pready)
		else $error("no ready after setup");
	ready_once_a: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	ready_cause_a: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access");
	idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0000)
		else $error("read data outside answer");
	err_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	err_decode_a: assert property (setup_s |=> o_pslverr == $past(bad))
		else $error("error flag against decode");
	reset_quiet_a: assert property ($fell(i_sys_rst) |->
		!o_irq && o_pending == 14'h0000)
		else $error("outputs not cleared by reset");
	pend_hold_a: assert property (calm_s [*7] |=> $stable(o_pending))
		else $error("pending moved with no cause");
endmodule : picb_asserts

bind picb_top picb_asserts picb_asserts_i (.i_sys_clk(i_sys_clk),
	.i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_src_event(i_src_event), .o_pending(o_pending), .o_irq(o_irq));

// [tb/picb_bench.sv]
/* Bench of the posted interrupt clear bank: APB tasks, event pulses.
 * Assumes header, package and design are compiled before it. */
`timescale 1ns/1ps
`include "picb_regs.svh"
module picb_bench;
	localparam logic [7:0] CL = `PICB_IDX_CLR_LOWER;
	localparam logic [7:0] CU = `PICB_IDX_CLR_UPPER;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [13:0] src = 14'h0000;
	logic [13:0] pend;
	logic        irq;
	logic [13:0] ex = 14'h0000;
	logic [31:0] rdat;
	logic        serr;
	int          err_count = 0;
	int          checked = 0;
	always #50 clk = ~clk;
	picb_top picb_top_i (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_src_event(src),
		.o_pending(pend), .o_irq(irq));
	// ********
	// Tasks
	// ********
	task automatic test_done;
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	// Entered just after a rising edge; leaves one idle cycle behind
	task automatic apb(input logic w, input logic [7:0] ix,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {6'h00, ix, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Ready, data and error are taken at the edge that sees ready
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			err_count++;
			test_done;
		end
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [7:0] ix, input logic [31:0] e);
		apb(1'b0, ix, 32'h0000_0000);
		chk("read data", rdat, e);
	endtask : rd
	task automatic out(input logic [13:0] ep, input logic ei);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("pending", pend, ep);
		chk("irq", irq, ei);
		@(posedge clk);
	endtask : out
	// ********
	// Sequence
	// ********
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(CL, 0);
		rd(`PICB_IDX_SW_EN, 0);
		rd(8'h10, 0);
		chk("slave error", serr, 1'b1);
		for (int i = 0; i < 14; i++)
		begin
			src[i] <= 1'b1;
			repeat (3) @(posedge clk);
			src[i] <= 1'b0;
			repeat (6) @(posedge clk);
			ex[i] = 1'b1;
			rd(CL, ex[7:0]);
			rd(CU, ex[13:8]);
		end
		out(14'h0000, 1'b0);
		apb(1'b1, `PICB_IDX_IRQ_MASK, 32'h3fff);
		out(14'h0000, 1'b1);
		rd(`PICB_IDX_IRQ_STAT, 32'h3fff);
		out(14'h0000, 1'b0);
		apb(1'b1, `PICB_IDX_MSK_LOWER, 32'hff);
		apb(1'b1, `PICB_IDX_MSK_UPPER, 32'h3f);
		out(14'h3fff, 1'b0);
		apb(1'b1, CL, 32'hfe);
		rd(CL, 32'hfe);
		apb(1'b1, CL, 32'h00);
		apb(1'b1, CU, 32'h00);
		rd(CU, 0);
		apb(1'b1, CL, 32'h00);
		rd(CL, 0);
		out(14'h0000, 1'b0);
		apb(1'b1, `PICB_IDX_SW_EN, 32'h1);
		apb(1'b1, CL, 32'h05);
		apb(1'b1, CU, 32'h21);
		apb(1'b1, CL, 32'h00);
		rd(CL, 32'h05);
		rd(CU, 32'h21);
		out(14'h2105, 1'b0);
		rd(`PICB_IDX_IRQ_STAT, 0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`PICB_IDX_SW_EN, 0);
		rd(CU, 0);
		test_done;
	end
endmodule : picb_bench
